// ==== inc/cca_pkg.sv ====
// Constants shared by the counter array capture/compare block
package cca_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_CTRL = 8'hD8;
    localparam logic [7:0] IDX_MODE = 8'hD9;
    localparam logic [7:0] IDX_MOD_MODE0 = 8'hDA;
    localparam logic [7:0] IDX_CNT_LOW = 8'hE0;
    localparam logic [7:0] IDX_CNT_HIGH = 8'hE1;
    localparam logic [7:0] IDX_VAL_LOW0 = 8'hE2;
    localparam logic [7:0] IDX_VAL_HIGH0 = 8'hE7;
    // Reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MOD_MODE = 8'h00;
    // Counter mode register fields
    localparam int MODE_IDLE_GATE = 7;
    localparam int MODE_GUARD_EN = 6;
    localparam int MODE_SRC_HI = 2;
    localparam int MODE_SRC_LO = 1;
    localparam int MODE_OVF_IRQ_EN = 0;
    localparam logic [7:0] MODE_MASK = 8'hC7;
    // Counter control register fields
    localparam int CTRL_OVF_FLAG = 7;
    localparam int CTRL_RUN = 6;
    localparam logic [7:0] CTRL_MASK = 8'hDF;
    // Module mode register fields
    localparam int MM_CMP_EN = 6;
    localparam int MM_RISE_CAP = 5;
    localparam int MM_FALL_CAP = 4;
    localparam int MM_HIT_FLAG = 3;
    localparam int MM_FLIP = 2;
    localparam int MM_PWM = 1;
    localparam int MM_IRQ_EN = 0;
    localparam logic [7:0] MM_MASK = 8'h7F;
    // Count source codes
    localparam logic [1:0] SRC_TIMER0 = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    // Oscillator divide for the internal count source
    localparam int OSC_DIV = 6;
    localparam logic [2:0] PRESC_LAST = 3'(OSC_DIV - 1);
    // Clock rate and pulse width of the module-4 guard reset
    localparam int CLK_MHZ = 25;
    localparam int GUARD_RST_NS = 1280;
    localparam int GUARD_RST_CYC = (GUARD_RST_NS * CLK_MHZ) / 1000;
endpackage

// ==== verilog/cca_top.sv ====
// Counter array: shared 16-bit counter with five capture/compare modules
module cca_top
    import cca_pkg::*;
#(
    parameter int NUM_MOD = 5,
    parameter int PIN_BASE = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // System inputs
    input wire logic idle_mode,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    // Port 1 pins, module pins on bits PIN_BASE upward
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe,
    // Shared interrupt request and module-4 guard reset
    output logic irq,
    output logic guard_reset
);
    // Register state
    logic [7:0] mode_q;
    logic [7:0] ctrl_q;
    logic [7:0] mod_mode_q [NUM_MOD];
    logic [15:0] val_q [NUM_MOD];
    logic [15:0] count_q;
    logic [2:0] presc_q;
    logic ext_prev_q;
    logic tick_q;
    logic [NUM_MOD-1:0] pin_prev_q;
    logic [NUM_MOD-1:0] flip_q;
    logic [NUM_MOD-1:0] pwm_q;
    logic [NUM_MOD-1:0] drive_q;
    logic [NUM_MOD-1:0] match_w;
    logic [NUM_MOD-1:0] capture_w;
    logic [NUM_MOD-1:0] pin_w;
    logic wait_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic [7:0] guard_cnt_q;
    logic guard_q;

    // Bus decode
    logic [7:0] idx;
    logic wr_go;
    logic wr_ok;
    logic [7:0] wbyte;
    logic src_pulse;
    logic gate_ok;
    logic tick;
    logic cnt_wr;
    logic wrap;
    logic [7:0] ctrl_base;
    logic [NUM_MOD-1:0] hits;
    logic any_mod;
    assign idx = address[9:2];
    assign wr_go = write && !wait_q;
    assign wr_ok = wr_go && byteenable[0];
    assign wbyte = writedata[7:0];

    // Module pins on port 1, module 0 at bit PIN_BASE
    assign pin_w = port1_in[PIN_BASE +: NUM_MOD];

    // Count source select; external pin counts falling edges, so it tops out at osc/2 with a sampled input
    always_comb begin
        unique case (mode_q[MODE_SRC_HI:MODE_SRC_LO])
            SRC_TIMER0: src_pulse = timer0_overflow;
            SRC_EXT: src_pulse = ext_prev_q && !external_count_input;
            default: src_pulse = (presc_q == PRESC_LAST);
        endcase
    end

    // Idle gate and run control decide whether the counter advances
    assign gate_ok = !(mode_q[MODE_IDLE_GATE] && idle_mode);
    assign tick = ctrl_q[CTRL_RUN] && gate_ok && src_pulse;

    // A byte write to the count beats a tick, so no wrap is seen in that cycle
    assign cnt_wr = wr_ok && (idx == IDX_CNT_LOW || idx == IDX_CNT_HIGH);
    assign wrap = tick && !cnt_wr && (count_q == 16'hFFFF);

    // Oscillator prescaler, free running so the phase does not depend on run
    always_ff @(posedge core_clk) begin
        if (reset) begin
            presc_q <= 3'h0;
        end else if (presc_q == PRESC_LAST) begin
            presc_q <= 3'h0;
        end else begin
            presc_q <= presc_q + 3'h1;
        end
    end

    // External count input edge history
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= external_count_input;
        end
    end

    // Shared up-counter; a software write of a byte wins over a tick
    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick;
            if (wr_ok && idx == IDX_CNT_LOW) begin
                count_q[7:0] <= wbyte;
            end else if (wr_ok && idx == IDX_CNT_HIGH) begin
                count_q[15:8] <= wbyte;
            end else if (tick) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // Match is judged on the cycle after each tick, against the new count
    genvar g;
    generate
        for (g = 0; g < NUM_MOD; g++) begin : g_mod
            logic rise;
            logic fall;
            assign rise = !pin_prev_q[g] && pin_w[g];
            assign fall = pin_prev_q[g] && !pin_w[g];
            assign match_w[g] = tick_q && mod_mode_q[g][MM_CMP_EN] && (count_q == val_q[g]);
            assign capture_w[g] = (rise && mod_mode_q[g][MM_RISE_CAP])
                || (fall && mod_mode_q[g][MM_FALL_CAP]);
            assign hits[g] = (match_w[g] && mod_mode_q[g][MM_HIT_FLAG]) || capture_w[g];

            // Mode register of this module
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    mod_mode_q[g] <= RST_MOD_MODE;
                end else if (wr_ok && idx == IDX_MOD_MODE0 + 8'(g)) begin
                    mod_mode_q[g] <= wbyte & MM_MASK;
                end
            end

            // Value pair; a capture beats a software write in the same cycle
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    val_q[g] <= 16'h0000;
                end else if (capture_w[g]) begin
                    val_q[g] <= count_q;
                end else if (wr_ok && idx == IDX_VAL_LOW0 + 8'(g)) begin
                    val_q[g][7:0] <= wbyte;
                end else if (wr_ok && idx == IDX_VAL_HIGH0 + 8'(g)) begin
                    val_q[g][15:8] <= wbyte;
                end
            end

            // Pin sampling, toggle output and PWM output
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    pin_prev_q[g] <= 1'b0;
                    flip_q[g] <= 1'b0;
                    pwm_q[g] <= 1'b0;
                    drive_q[g] <= 1'b0;
                end else begin
                    pin_prev_q[g] <= pin_w[g];
                    if (match_w[g] && mod_mode_q[g][MM_FLIP]) begin
                        flip_q[g] <= !flip_q[g];
                    end
                    // High while the low count byte has reached the low value byte
                    pwm_q[g] <= (count_q[7:0] >= val_q[g][7:0]);
                    drive_q[g] <= mod_mode_q[g][MM_PWM] || mod_mode_q[g][MM_FLIP];
                end
            end

            // Checks of this module's flag, interrupt and pin
            hit_flag_a: assert property (@(posedge core_clk) disable iff (reset)
                (match_w[g] && mod_mode_q[g][MM_HIT_FLAG]) |=> ctrl_q[g] ##1 (irq_q || !mod_mode_q[g][MM_IRQ_EN]))
                else $error("match did not set module flag");
            mod_flag_hold_a: assert property (@(posedge core_clk) disable iff (reset)
                (ctrl_q[g] && !(wr_ok && idx == IDX_CTRL)) |=> ctrl_q[g])
                else $error("module flag cleared without software write");
            mod_irq_a: assert property (@(posedge core_clk) disable iff (reset)
                (ctrl_q[g] && mod_mode_q[g][MM_IRQ_EN]) |=> irq_q)
                else $error("enabled module flag did not raise interrupt");
            toggle_pin_a: assert property (@(posedge core_clk) disable iff (reset)
                (match_w[g] && mod_mode_q[g][MM_FLIP] && !mod_mode_q[g][MM_PWM])
                |=> ##1 (port1_out[PIN_BASE + g] != $past(port1_out[PIN_BASE + g])))
                else $error("pin did not invert on match");
        end
    endgenerate

    // Software write forms the base; hardware sets are ORed on top
    assign ctrl_base = (wr_ok && idx == IDX_CTRL) ? (wbyte & CTRL_MASK) : ctrl_q;

    // Control register: set by hardware wins over a software clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q <= RST_CTRL;
        end else begin
            ctrl_q[CTRL_RUN] <= ctrl_base[CTRL_RUN];
            ctrl_q[5] <= 1'b0;
            ctrl_q[CTRL_OVF_FLAG] <= ctrl_base[CTRL_OVF_FLAG] || wrap;
            ctrl_q[NUM_MOD-1:0] <= ctrl_base[NUM_MOD-1:0] | hits;
        end
    end

    // Counter mode register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_q <= RST_MODE;
        end else if (wr_ok && idx == IDX_MODE) begin
            mode_q <= wbyte & MODE_MASK;
        end
    end

    // Any module flag whose interrupt is enabled
    always_comb begin
        any_mod = 1'b0;
        for (int i = 0; i < NUM_MOD; i++) begin
            any_mod = any_mod || (ctrl_q[i] && mod_mode_q[i][MM_IRQ_EN]);
        end
    end

    // One interrupt line for overflow and all module flags
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= any_mod || (ctrl_q[CTRL_OVF_FLAG] && mode_q[MODE_OVF_IRQ_EN]);
        end
    end

    // Module-4 guard: a match while enabled pulses the reset output for a fixed width
    always_ff @(posedge core_clk) begin
        if (reset) begin
            guard_cnt_q <= 8'h00;
            guard_q <= 1'b0;
        end else if (mode_q[MODE_GUARD_EN] && match_w[NUM_MOD-1]) begin
            guard_cnt_q <= 8'(GUARD_RST_CYC - 1);
            guard_q <= 1'b1;
        end else if (guard_cnt_q != 8'h00) begin
            guard_cnt_q <= guard_cnt_q - 8'h01;
        end else begin
            guard_q <= 1'b0;
        end
    end

    // One wait cycle per access; read data are ready as waitrequest drops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((read || write) && wait_q);
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (read && wait_q) begin
            rdata_q <= 32'h0000_0000;
            if (idx == IDX_CTRL) begin
                rdata_q[7:0] <= ctrl_q;
            end else if (idx == IDX_MODE) begin
                rdata_q[7:0] <= mode_q;
            end else if (idx == IDX_CNT_LOW) begin
                rdata_q[7:0] <= count_q[7:0];
            end else if (idx == IDX_CNT_HIGH) begin
                rdata_q[7:0] <= count_q[15:8];
            end
            for (int i = 0; i < NUM_MOD; i++) begin
                if (idx == IDX_MOD_MODE0 + 8'(i)) begin
                    rdata_q[7:0] <= mod_mode_q[i];
                end
                if (idx == IDX_VAL_LOW0 + 8'(i)) begin
                    rdata_q[7:0] <= val_q[i][7:0];
                end
                if (idx == IDX_VAL_HIGH0 + 8'(i)) begin
                    rdata_q[7:0] <= val_q[i][15:8];
                end
            end
        end
    end

    // Port 1 outputs; bits without a module stay undriven
    always_ff @(posedge core_clk) begin
        if (reset) begin
            port1_out <= 8'h00;
            port1_oe <= 8'h00;
        end else begin
            port1_out <= 8'h00;
            port1_oe <= 8'h00;
            for (int i = 0; i < NUM_MOD; i++) begin
                port1_out[PIN_BASE + i] <= mod_mode_q[i][MM_PWM] ? pwm_q[i] : flip_q[i];
                port1_oe[PIN_BASE + i] <= drive_q[i];
            end
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign irq = irq_q;
    assign guard_reset = guard_q;

    // Checks of the counter and flags
    ovf_flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
        (tick && !cnt_wr && count_q == 16'hFFFF) |=> (ctrl_q[CTRL_OVF_FLAG] && count_q == 16'h0000))
        else $error("overflow did not set flag on wrap");
    ovf_flag_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        (ctrl_q[CTRL_OVF_FLAG] && !(wr_ok && idx == IDX_CTRL)) |=> ctrl_q[CTRL_OVF_FLAG])
        else $error("overflow flag cleared without software write");
    run_stop_a: assert property (@(posedge core_clk) disable iff (reset)
        (!ctrl_q[CTRL_RUN] && !wr_ok) |=> (count_q == $past(count_q)))
        else $error("counter moved while stopped");
    idle_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        (mode_q[MODE_IDLE_GATE] && idle_mode && !wr_ok) |=> (count_q == $past(count_q)))
        else $error("counter ticked while gated in idle");
    timer0_src_a: assert property (@(posedge core_clk) disable iff (reset)
        (ctrl_q[CTRL_RUN] && !idle_mode && mode_q[MODE_SRC_HI:MODE_SRC_LO] == SRC_TIMER0 && timer0_overflow && !wr_ok)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("timer 0 overflow not counted");
    irq_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        (ctrl_q[CTRL_OVF_FLAG] && !mode_q[MODE_OVF_IRQ_EN] && ctrl_q[NUM_MOD-1:0] == '0) |=> !irq_q)
        else $error("overflow interrupt raised while disabled");
    irq_share_a: assert property (@(posedge core_clk) disable iff (reset)
        (ctrl_q[CTRL_OVF_FLAG] && mode_q[MODE_OVF_IRQ_EN]) |=> irq_q)
        else $error("enabled overflow flag did not raise interrupt");
    guard_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (guard_q && guard_cnt_q != 8'h00) |=> guard_q)
        else $error("guard reset pulse ended early");
    capture_load_a: assert property (@(posedge core_clk) disable iff (reset)
        (mod_mode_q[0][MM_RISE_CAP] && !pin_prev_q[0] && pin_w[0])
        |=> (val_q[0] == $past(count_q) && ctrl_q[0]))
        else $error("rising edge did not capture count");
    bus_answer_a: assert property (@(posedge core_clk) disable iff (reset)
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("bus access not answered in one wait cycle");

    // Main scenarios
    cov_overflow_c: cover property (@(posedge core_clk) disable iff (reset)
        tick && count_q == 16'hFFFF);
    cov_capture_c: cover property (@(posedge core_clk) disable iff (reset) |capture_w);
    cov_guard_c: cover property (@(posedge core_clk) disable iff (reset) $rose(guard_q));
    cov_irq_c: cover property (@(posedge core_clk) disable iff (reset) $rose(irq_q));
    cov_match_c: cover property (@(posedge core_clk) disable iff (reset) |match_w);
endmodule

// ==== bench/cca_pin_model.sv ====
// Pin-side partner: port-1 module pins and the external count input
module cca_pin_model (
    // Clock
    input wire logic core_clk,
    // Device pin drive
    input wire logic [7:0] port1_out,
    input wire logic [7:0] port1_oe,
    // Resolved pin levels
    output logic [7:0] port1_in,
    output logic external_count_input
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] drive_q = 8'h00;
    logic ext_q = 1'b1;

    // Device wins where it enables its pin, outside level elsewhere
    assign port1_in = (port1_oe & port1_out) | (~port1_oe & drive_q);
    assign external_count_input = ext_q;

    // Outside level change just after an edge gives capture edges
    task automatic set_pin(input int bit_no, input logic level);
        @(posedge core_clk);
        drive_q[bit_no] <= level;
    endtask

    // Falling edges; hold of two or more keeps the rate at or under osc/4
    task automatic ext_edges(input int n, input int hold);
        repeat (n) begin
            @(posedge core_clk);
            ext_q <= 1'b0;
            repeat (hold) @(posedge core_clk);
            ext_q <= 1'b1;
            repeat (hold - 1) @(posedge core_clk);
        end
    endtask
endmodule

// ==== bench/test_counter_array_capture_compare.sv ====
// Self-checking bench for the counter array block
module test_counter_array_capture_compare import cca_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic idle_mode = 1'b0;
    logic timer0_overflow = 1'b0;
    wire logic [31:0] readdata;
    wire logic waitrequest, irq, guard_reset, external_count_input;
    wire logic [7:0] port1_in, port1_out, port1_oe;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int guard_run = 0;
    logic [7:0] rd;

    cca_top dut (.core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .idle_mode(idle_mode), .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
        .port1_in(port1_in), .port1_out(port1_out), .port1_oe(port1_oe), .irq(irq), .guard_reset(guard_reset));
    cca_pin_model pins (.core_clk(core_clk), .port1_out(port1_out), .port1_oe(port1_oe),
        .port1_in(port1_in), .external_count_input(external_count_input));

    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    // Cycle count for the hang guard and length of the guard reset pulse
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (guard_reset === 1'b1) guard_run <= guard_run + 1;
    end

    task automatic conclude();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Range compare where the prescaler phase is unknown
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Bus cycles hold the request until waitrequest is seen low
    task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        write <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] idx);
        @(posedge core_clk);
        address <= {idx, 2'b00};
        read <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        read <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            timer0_overflow <= 1'b1;
            @(posedge core_clk);
            timer0_overflow <= 1'b0;
        end
    endtask

    task automatic set_count(input logic [15:0] v);
        bus_wr(IDX_CNT_LOW, v[7:0]);
        bus_wr(IDX_CNT_HIGH, v[15:8]);
    endtask

    task automatic t_regs();
        bus_rd(IDX_CTRL); chk(rd, RST_CTRL);
        bus_rd(IDX_MODE); chk(rd, RST_MODE);
        for (int i = 0; i < 5; i++) begin
            bus_rd(IDX_MOD_MODE0 + 8'(i)); chk(rd, RST_MOD_MODE);
        end
        bus_wr(IDX_MODE, 8'hFF); bus_rd(IDX_MODE); chk(rd, 8'hC7);
        bus_wr(IDX_MOD_MODE0, 8'hFF); bus_rd(IDX_MOD_MODE0); chk(rd, 8'h7F);
        bus_wr(8'h10, 8'hFF); bus_rd(8'h10); chk(rd, 8'h00);
        bus_wr(IDX_MODE, 8'h00);
        bus_wr(IDX_MOD_MODE0, 8'h00);
    endtask

    // Both oscillator codes give one count per six clocks, then stop holds
    task automatic t_osc();
        logic [7:0] held;
        for (int s = 0; s < 2; s++) begin
            bus_wr(IDX_MODE, 8'(s * 2)); set_count(16'h0000);
            bus_wr(IDX_CTRL, 8'h40); cyc(60); bus_wr(IDX_CTRL, 8'h00);
            bus_rd(IDX_CNT_LOW); held = rd; chk_rng(rd, 8'h09, 8'h0C);
            cyc(30); bus_rd(IDX_CNT_LOW); chk(rd, held);
        end
    endtask

    task automatic t_src();
        set_count(16'h0000); bus_wr(IDX_MODE, 8'h04); bus_wr(IDX_CTRL, 8'h40);
        tick(10); cyc(3); bus_rd(IDX_CNT_LOW); chk(rd, 8'h0A);
        @(posedge core_clk); idle_mode <= 1'b1;
        bus_wr(IDX_MODE, 8'h84); tick(4); cyc(3); bus_rd(IDX_CNT_LOW); chk(rd, 8'h0A);
        bus_wr(IDX_MODE, 8'h04); tick(4); cyc(3); bus_rd(IDX_CNT_LOW); chk(rd, 8'h0E);
        @(posedge core_clk); idle_mode <= 1'b0;
        bus_wr(IDX_MODE, 8'h06); pins.ext_edges(3, 2); pins.ext_edges(4, 5);
        cyc(3); bus_rd(IDX_CNT_LOW); chk(rd, 8'h15);
        bus_wr(IDX_CTRL, 8'h00);
    endtask

    task automatic t_ovf();
        bus_wr(IDX_MODE, 8'h04); set_count(16'hFFFF); bus_wr(IDX_CTRL, 8'h40);
        tick(1); cyc(3); bus_rd(IDX_CNT_HIGH); chk(rd, 8'h00);
        bus_rd(IDX_CTRL); chk(rd, 8'hC0);
        chk({7'h0, irq}, 8'h00);
        bus_wr(IDX_MODE, 8'h05); cyc(2); chk({7'h0, irq}, 8'h01);
        tick(3); bus_rd(IDX_CTRL); chk(rd, 8'hC0);
        bus_wr(IDX_CTRL, 8'h00); cyc(2); bus_rd(IDX_CTRL); chk(rd, 8'h00);
        chk({7'h0, irq}, 8'h00);
        bus_wr(IDX_MODE, 8'h04);
    endtask

    // Module 1 timer with pin flip: nothing before count 5, all at it
    task automatic t_match();
        set_count(16'h0000); bus_wr(IDX_VAL_LOW0 + 8'h01, 8'h05); bus_wr(IDX_VAL_HIGH0 + 8'h01, 8'h00);
        bus_wr(IDX_MOD_MODE0 + 8'h01, 8'h4D); bus_wr(IDX_CTRL, 8'h40);
        tick(4); cyc(4); bus_rd(IDX_CTRL); chk(rd, 8'h40);
        chk({7'h0, port1_out[4]}, 8'h00);
        tick(1); cyc(4); bus_rd(IDX_CTRL); chk(rd, 8'h42);
        chk({7'h0, port1_out[4]}, 8'h01);
        chk({1'b0, port1_oe[7:5], port1_oe[3:0]}, 8'h00);
        chk({7'h0, irq}, 8'h01);
        bus_wr(IDX_MOD_MODE0 + 8'h01, 8'h4C); cyc(3); chk({7'h0, irq}, 8'h00);
        bus_wr(IDX_CTRL, 8'h00); bus_wr(IDX_MOD_MODE0 + 8'h01, 8'h00);
    endtask

    // Module 0 capture: rising only, then falling only
    task automatic t_cap();
        set_count(16'h1234); bus_wr(IDX_MOD_MODE0, 8'h20); pins.set_pin(3, 1'b1); cyc(4);
        bus_rd(IDX_VAL_LOW0); chk(rd, 8'h34);
        bus_rd(IDX_VAL_HIGH0); chk(rd, 8'h12);
        bus_rd(IDX_CTRL); chk(rd, 8'h01);
        set_count(16'h0042); pins.set_pin(3, 1'b0); cyc(4); bus_rd(IDX_VAL_LOW0); chk(rd, 8'h34);
        bus_wr(IDX_MOD_MODE0, 8'h10); pins.set_pin(3, 1'b1); cyc(4);
        bus_rd(IDX_VAL_LOW0); chk(rd, 8'h34);
        pins.set_pin(3, 1'b0); cyc(4); bus_rd(IDX_VAL_LOW0); chk(rd, 8'h42);
        bus_wr(IDX_MOD_MODE0, 8'h00); bus_wr(IDX_CTRL, 8'h00);
    endtask

    // Module 2 duty: high at and above the value, low below
    task automatic t_pwm();
        bus_wr(IDX_VAL_LOW0 + 8'h02, 8'h80); bus_wr(IDX_MOD_MODE0 + 8'h02, 8'h42);
        set_count(16'h0090); cyc(3); chk({6'h00, port1_oe[5], port1_out[5]}, 8'h03);
        set_count(16'h0010); cyc(3); chk({7'h0, port1_out[5]}, 8'h00);
        set_count(16'h0080); cyc(3); chk({7'h0, port1_out[5]}, 8'h01);
        bus_wr(IDX_MOD_MODE0 + 8'h02, 8'h00);
    endtask

    // Module 4 match with the guard enabled, then disabled
    task automatic t_guard();
        int run_start;
        bus_wr(IDX_VAL_LOW0 + 8'h04, 8'h03); bus_wr(IDX_VAL_HIGH0 + 8'h04, 8'h00);
        bus_wr(IDX_MOD_MODE0 + 8'h04, 8'h48);
        for (int g = 1; g >= 0; g--) begin
            bus_wr(IDX_CTRL, 8'h00); bus_wr(IDX_MODE, g ? 8'h44 : 8'h04); set_count(16'h0000);
            run_start = guard_run;
            bus_wr(IDX_CTRL, 8'h40); tick(3); cyc(60);
            chk(8'(guard_run - run_start), g ? 8'(GUARD_RST_CYC) : 8'h00);
        end
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        // Scenarios race the hang guard; whichever ends first leads to the verdict
        fork
            begin
                t_regs();
                t_osc();
                t_src();
                t_ovf();
                t_match();
                t_cap();
                t_pwm();
                t_guard();
            end
            begin
                wait (cycles >= 20000);
                err_total++;
            end
        join_any
        conclude();
    end
endmodule
